// File: rtl/bstap_map.vh
`ifndef BSTAP_MAP_VH
`define BSTAP_MAP_VH
`define BSTAP_IR_W 4
`define BSTAP_IR_EXTEST 4'h0
`define BSTAP_IR_SAMPLE 4'h1
`define BSTAP_IR_CLAMP 4'h2
`define BSTAP_IR_HIGHZ 4'h3
`define BSTAP_IR_BYPASS 4'hf
`define BSTAP_IR_CAPTURE 4'h1
`define BSTAP_CELL_IN 2
`define BSTAP_CELL_CTL 1
`define BSTAP_CELL_OUT 0
`define BSTAP_CELLS_PER_PIN 3
`endif

// File: rtl/bstap_sync.v
`timescale 1ns/1ps
`default_nettype none
module bstap_sync #(
    parameter W = 1
) (
    input wire clk_sys,
    input wire [W-1:0] asyncIn,
    output reg [W-1:0] syncOut
);
    reg [W-1:0] meta_reg;
    // First stage is read only by the second stage
    always @(posedge clk_sys) begin
        meta_reg <= asyncIn;
        syncOut <= meta_reg;
    end
endmodule // bstap_sync
`default_nettype wire

// File: rtl/bstap_tap.v
// Functional notes
// R1: TAP follows TMS on rising TCK
// R2: TDI taken rising, shifted on falling edge
// R3: TDO changes only on falling TCK
// R4: TDO driven only in Shift-DR or Shift-IR
// R5: TRST low forces Test-Logic-Reset immediately
// R6: Scan path shifts LSB first
// R7: Pulled-up pin samples 1; tester clears control
// R8: Open-drain with OUT 1 samples control 0
// R9: Open-drain with OUT 0 samples control 1
// R10: EXTEST, CLAMP, HIGHZ hold core in standby
// R11: Tester sets mode pins before leaving isolation
// R12: Tester runs TCK slower than system clock
// R13: Tester pulses TRST low at power-on
// R14: Idle tester leaves TCK, TMS, TDI floating; bstap_tester drives them at all times
// R15: Test inputs have internal pull-ups
// R16: Pin cells IN, control, OUT descending
`timescale 1ns/1ps
`default_nettype none
`include "bstap_map.vh"
module bstap_tap #(
    parameter NPINS = 19
) (
    input wire clk_sys,
    input wire reset,
    input wire tckIn,
    input wire tmsIn,
    input wire tdiIn,
    input wire trstN,
    output reg tdoOut,
    output reg tdoOe,
    output reg [3:0] pullUpEn,
    input wire [NPINS-1:0] pinIn,
    input wire [NPINS-1:0] pinOut,
    input wire [NPINS-1:0] pinDirOut,
    input wire [NPINS-1:0] pinPullUp,
    input wire [NPINS-1:0] pinOpenDrain,
    output reg [NPINS-1:0] bsOut,
    output reg [NPINS-1:0] bsDirOut,
    output reg bsDriveEn,
    output reg coreResetN,
    output reg coreStandbyN
);
    localparam NC = NPINS * `BSTAP_CELLS_PER_PIN;
    localparam [15:0] S_TLR = 16'h0001;
    localparam [15:0] S_RTI = 16'h0002;
    localparam [15:0] S_SDS = 16'h0004;
    localparam [15:0] S_CDR = 16'h0008;
    localparam [15:0] S_SHDR = 16'h0010;
    localparam [15:0] S_E1DR = 16'h0020;
    localparam [15:0] S_PDR = 16'h0040;
    localparam [15:0] S_E2DR = 16'h0080;
    localparam [15:0] S_UDR = 16'h0100;
    localparam [15:0] S_SIS = 16'h0200;
    localparam [15:0] S_CIR = 16'h0400;
    localparam [15:0] S_SHIR = 16'h0800;
    localparam [15:0] S_E1IR = 16'h1000;
    localparam [15:0] S_PIR = 16'h2000;
    localparam [15:0] S_E2IR = 16'h4000;
    localparam [15:0] S_UIR = 16'h8000;

    wire [3:0] syncIn;
    reg tckPrev_reg;
    reg [15:0] state_reg;
    reg [15:0] state_next;
    reg tdiCap_reg;
    reg [`BSTAP_IR_W-1:0] irShift_reg;
    reg [`BSTAP_IR_W-1:0] ir_reg;
    reg [NC-1:0] bsrShift_reg;
    reg [NC-1:0] bsrUpd_reg;
    reg bypass_reg;
    reg [NC-1:0] capVec;
    reg doShift_reg;
    // Separate loop indices keep each process the only writer of its own
    integer i;
    integer j;

    // TRST is sampled too; its effect is one sync delay, with no TCK needed
    bstap_sync #(.W(4)) uSync (
        .clk_sys(clk_sys),
        .asyncIn({tckIn, tmsIn, tdiIn, trstN}),
        .syncOut(syncIn)
    );
    wire tck = syncIn[3];
    wire tms = syncIn[2];
    wire tdi = syncIn[1];
    wire trstOk = syncIn[0];
    // Each TCK phase must last a few system clocks or the edge detector
    // misses it; this is why TCK has to run well below the system clock
    wire tckRise = tck & ~tckPrev_reg;
    wire tckFall = ~tck & tckPrev_reg;
    wire selBsr = (ir_reg == `BSTAP_IR_EXTEST) |
        (ir_reg == `BSTAP_IR_SAMPLE);
    // Isolating codes hand the pins over to the boundary cells
    wire isolate = (ir_reg == `BSTAP_IR_EXTEST) |
        (ir_reg == `BSTAP_IR_CLAMP) | (ir_reg == `BSTAP_IR_HIGHZ);

    // Next state is always formed; it only lands on a seen TCK rise
    always @* begin
        case (state_reg)
            S_TLR: state_next = tms ? S_TLR : S_RTI; // R1
            S_RTI: state_next = tms ? S_SDS : S_RTI;
            S_SDS: state_next = tms ? S_SIS : S_CDR;
            S_CDR: state_next = tms ? S_E1DR : S_SHDR;
            S_SHDR: state_next = tms ? S_E1DR : S_SHDR;
            S_E1DR: state_next = tms ? S_UDR : S_PDR;
            S_PDR: state_next = tms ? S_E2DR : S_PDR;
            S_E2DR: state_next = tms ? S_UDR : S_SHDR;
            S_UDR: state_next = tms ? S_SDS : S_RTI;
            S_SIS: state_next = tms ? S_TLR : S_CIR;
            S_CIR: state_next = tms ? S_E1IR : S_SHIR;
            S_SHIR: state_next = tms ? S_E1IR : S_SHIR;
            S_E1IR: state_next = tms ? S_UIR : S_PIR;
            S_PIR: state_next = tms ? S_E2IR : S_PIR;
            S_E2IR: state_next = tms ? S_UIR : S_SHIR;
            S_UIR: state_next = tms ? S_SDS : S_RTI;
            default: state_next = S_TLR;
        endcase
    end

    // Capture vector: per pin IN, control, OUT with pin 0 at the top
    // Pulled-up pins read 1; open-drain control mirrors a pad held low
    always @* begin
        capVec = {NC{1'b0}};
        for (i = 0; i < NPINS; i = i + 1) begin
            capVec[NC-1-3*i] = pinPullUp[i] ? 1'b1 : pinIn[i]; // R16 R7
            if (pinOpenDrain[i])
                capVec[NC-2-3*i] = ~pinOut[i]; // R8 R9
            else
                capVec[NC-2-3*i] = pinDirOut[i];
            capVec[NC-3-3*i] = pinOut[i];
        end
    end

    // TMS and TDI share the TCK synchroniser, so they line up with its edge
    always @(posedge clk_sys) begin
        if (reset) begin
            tckPrev_reg <= 1'b0;
            state_reg <= S_TLR;
            tdiCap_reg <= 1'b0;
            doShift_reg <= 1'b0;
            irShift_reg <= {`BSTAP_IR_W{1'b0}};
            ir_reg <= `BSTAP_IR_BYPASS;
            bsrShift_reg <= {NC{1'b0}};
            bsrUpd_reg <= {NC{1'b0}};
            bypass_reg <= 1'b0;
            tdoOut <= 1'b0;
            tdoOe <= 1'b0;
        end else if (!trstOk) begin
            tckPrev_reg <= tck;
            state_reg <= S_TLR; // R5
            ir_reg <= `BSTAP_IR_BYPASS;
            // Shift registers keep their contents; the next capture wins
            doShift_reg <= 1'b0;
            tdoOe <= 1'b0;
        end else begin
            tckPrev_reg <= tck;
            if (tckRise) begin
                state_reg <= state_next; // R1
                tdiCap_reg <= tdi; // R2
                // Remembers that this rise was taken in a shift state
                doShift_reg <= (state_reg == S_SHDR) | (state_reg == S_SHIR);
                if (state_reg == S_TLR)
                    ir_reg <= `BSTAP_IR_BYPASS;
                if (state_reg == S_CIR)
                    irShift_reg <= `BSTAP_IR_CAPTURE;
                if (state_reg == S_CDR) begin
                    bypass_reg <= 1'b0;
                    if (selBsr)
                        bsrShift_reg <= capVec;
                end
                if (state_reg == S_UIR)
                    ir_reg <= irShift_reg;
                if (state_reg == S_UDR && selBsr)
                    bsrUpd_reg <= bsrShift_reg;
            end
            if (tckFall) begin
                // Shift enters at MSB so bit 0 leaves first
                if (doShift_reg && (state_reg == S_SHIR ||
                    state_reg == S_E1IR))
                    irShift_reg <= {tdiCap_reg,
                        irShift_reg[`BSTAP_IR_W-1:1]}; // R2 R6
                else if (doShift_reg && selBsr)
                    bsrShift_reg <= {tdiCap_reg, bsrShift_reg[NC-1:1]}; // R6
                else if (doShift_reg)
                    bypass_reg <= tdiCap_reg;
                tdoOe <= (state_reg == S_SHDR) | (state_reg == S_SHIR); // R4
                // TDO shows the bit that leads after this edge's shift, so
                // a shifting edge presents bit 1, not the bit just consumed
                if (state_reg == S_SHIR)
                    tdoOut <= doShift_reg ? irShift_reg[1] :
                        irShift_reg[0]; // R3 R6
                else if (state_reg == S_SHDR && selBsr)
                    tdoOut <= doShift_reg ? bsrShift_reg[1] :
                        bsrShift_reg[0]; // R3 R6
                else if (state_reg == S_SHDR)
                    tdoOut <= doShift_reg ? tdiCap_reg : bypass_reg; // R3
            end
        end
    end

    // Pin drive during isolation: HIGHZ floats, others use update cells
    // Update cells are copied every cycle; bsDriveEn says who owns the pins
    always @(posedge clk_sys) begin
        if (reset) begin
            bsOut <= {NPINS{1'b0}};
            bsDirOut <= {NPINS{1'b0}};
            bsDriveEn <= 1'b0;
            coreResetN <= 1'b1;
            coreStandbyN <= 1'b1;
            pullUpEn <= 4'hf;
        end else begin
            for (j = 0; j < NPINS; j = j + 1) begin
                bsOut[j] <= bsrUpd_reg[NC-3-3*j]; // R16
                bsDirOut[j] <= (ir_reg != `BSTAP_IR_HIGHZ) &
                    bsrUpd_reg[NC-2-3*j];
            end
            bsDriveEn <= isolate & trstOk;
            coreResetN <= ~(isolate & trstOk); // R10
            coreStandbyN <= ~(isolate & trstOk); // R10
            pullUpEn <= 4'hf; // R15
        end
    end
endmodule // bstap_tap
`default_nettype wire

// File: tb/bstap_tap_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bstap_tap_sva (
    input wire clk_sys,
    input wire reset,
    input wire tckIn,
    input wire trstN,
    input wire tdoOut,
    input wire tdoOe,
    input wire [3:0] pullUpEn,
    input wire bsDriveEn,
    input wire coreResetN,
    input wire coreStandbyN
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    pullups_on_a: assert property (pullUpEn == 4'hf)
        else $error("test pin pull-ups not all on");
    tdo_fall_only_a: assert property ($changed(tdoOut) |-> !$past(tckIn, 2))
        else $error("tdo data moved while tck high");
    oe_fall_only_a: assert property ($changed(tdoOe) |-> !$past(tckIn, 2))
        else $error("tdo enable moved while tck high");
    oe_holds_a: assert property ($rose(tdoOe) |-> tdoOe [*8])
        else $error("tdo enable pulsed short");
    tdo_holds_a: assert property ($changed(tdoOut) |=> $stable(tdoOut) [*8])
        else $error("tdo data changed twice in a half period");
    core_guarded_a: assert property (coreStandbyN == coreResetN
        && bsDriveEn == !coreResetN)
        else $error("core guard and boundary ownership disagree");
    trst_release_a: assert property ($fell(trstN)
        |-> ##[1:6] (coreResetN && !bsDriveEn && !tdoOe))
        else $error("test reset did not release core");
    isolate_rise_a: assert property ($rose(bsDriveEn) |-> tckIn)
        else $error("isolation began away from a tck rise");
endmodule // bstap_tap_sva
bind bstap_tap bstap_tap_sva i_sva (.clk_sys(clk_sys), .reset(reset),
    .tckIn(tckIn), .trstN(trstN), .tdoOut(tdoOut), .tdoOe(tdoOe),
    .pullUpEn(pullUpEn), .bsDriveEn(bsDriveEn), .coreResetN(coreResetN),
    .coreStandbyN(coreStandbyN));
`default_nettype wire

// File: tb/bstap_tester.sv
`timescale 1ns/1ps
`default_nettype none
module bstap_tester (
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trstN,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        // TMS and TDI idle at the 1 the internal pull-ups would give; TCK idles low
        tms = 1'b1;
        tdi = 1'b1;
        trstN = 1'b0;
    end
    // TCK stays low here so the pulse never races a clock edge
    task automatic pulse_trst();
        trstN = 1'b0;
        #100 trstN = 1'b1;
        #100;
    endtask
    // 125 ns period, far slower than the system clock
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #60 tck = 1'b1;
        o = tdo;
        // TDI moves while TCK is high; only the rising edge may take it
        #30 tdi = ~d;
        #35 tck = 1'b0;
    endtask
    // Starts and ends in Run-Test/Idle
    task automatic scan(input logic ir, input int n, input logic [15:0] din,
        output logic [15:0] dout);
        logic o;
        dout = '0;
        tick(1'b1, 1'b0, o);
        if (ir) tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
        tick(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
    endtask
endmodule // bstap_tester
`default_nettype wire

// File: tb/bstap_tap_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bstap_tap_tb_top;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [2:0] pinIn = '0, pinOut = '0, pinDir = '0, pinPu = '0, pinOd = '0;
    wire tckIn, tmsIn, tdiIn, trstN, tdoOut, tdoOe, bsDriveEn, coreResetN;
    wire coreStandbyN;
    wire tdoLine;
    wire [3:0] pullUpEn;
    wire [2:0] bsOut;
    wire [2:0] bsDirOut;
    logic [15:0] got;
    int mismatches = 0, checked = 0;
    always #2.5 clk_sys = ~clk_sys;
    // A released TDO shows the inverse, so a sample taken too late fails
    assign tdoLine = tdoOe ? tdoOut : ~tdoOut;
    bstap_tester i_tester (.tck(tckIn), .tms(tmsIn), .tdi(tdiIn),
        .trstN(trstN), .tdo(tdoLine));
    bstap_tap #(.NPINS(3)) i_dut (.clk_sys(clk_sys), .reset(reset),
        .tckIn(tckIn), .tmsIn(tmsIn), .tdiIn(tdiIn), .trstN(trstN),
        .tdoOut(tdoOut), .tdoOe(tdoOe), .pullUpEn(pullUpEn), .pinIn(pinIn),
        .pinOut(pinOut), .pinDirOut(pinDir), .pinPullUp(pinPu),
        .pinOpenDrain(pinOd), .bsOut(bsOut), .bsDirOut(bsDirOut),
        .bsDriveEn(bsDriveEn),
        .coreResetN(coreResetN), .coreStandbyN(coreStandbyN));
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] seen);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic test_ir_bypass();
        i_tester.scan(1'b1, 4, 16'hf, got);
        check("ir capture", 16'h1, got);
        check("tdo enable idle", 16'h0, {15'h0, tdoOe});
        check("pull-ups", 16'hf, {12'h0, pullUpEn});
        i_tester.scan(1'b0, 2, 16'h1, got);
        check("bypass path", 16'h2, got);
        $display("test_ir_bypass done");
    endtask
    task automatic test_sample();
        @(posedge clk_sys);
        #1 {pinPu, pinOd, pinOut, pinDir} = {3'b001, 3'b110, 3'b010, 3'b001};
        i_tester.scan(1'b1, 4, 16'h1, got);
        i_tester.scan(1'b0, 9, 16'h0, got);
        check("sample cells", 16'h18a, got);
        $display("test_sample done");
    endtask
    // Each isolating code must guard the core; test reset must undo it
    task automatic test_isolate();
        logic [3:0] codes[3] = '{4'h0, 4'h2, 4'h3};
        // Preload: the shifted data sets pin 0's control cell to 0 and the other two to 1
        i_tester.scan(1'b1, 4, 16'h1, got);
        i_tester.scan(1'b0, 9, 16'h53, got);
        foreach (codes[k]) begin
            i_tester.scan(1'b1, 4, {12'h0, codes[k]}, got);
            check("guarded", 16'h4, {13'h0, bsDriveEn, coreResetN,
                coreStandbyN});
            check("pin drive", 16'h5, {13'h0, bsOut});
            check("pin direction", (codes[k] == 4'h3) ? 16'h0 : 16'h6,
                {13'h0, bsDirOut});
            // Mode, reset and standby levels settle before isolation ends
            pinIn = 3'b111;
            i_tester.pulse_trst();
            check("released", 16'h3, {13'h0, bsDriveEn, coreResetN,
                coreStandbyN});
            i_tester.tick(1'b0, 1'b0, got[0]);
        end
        $display("test_isolate done");
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        #1 reset = 1'b0;
        i_tester.pulse_trst();
        i_tester.tick(1'b0, 1'b0, got[0]);
        test_ir_bypass();
        test_sample();
        test_isolate();
        final_report();
    end
    // Whole run is about 13 us of TCK traffic
    initial begin
        #300000;
        mismatches++;
        final_report();
    end
endmodule // bstap_tap_tb_top
`default_nettype wire
